/* File: pfsm_defines.svh */
/*
 Constants for the pad function select multiplexer: key value, field
 positions of a pad configuration word, select codes and reset values.
 Assumes inclusion by bare name, once per compilation unit.
*/
`ifndef PFSM_DEFINES_SVH
`define PFSM_DEFINES_SVH

`define PFSM_KEY_UNLOCK      8'h73
`define PFSM_NUM_PADS        105
`define PFSM_NUM_REGS        128
`define PFSM_CFG_W           16
`define PFSM_FSEL_LSB        0
`define PFSM_FSEL_W          4
`define PFSM_DS_LSB          4
`define PFSM_DS_W            2
`define PFSM_PULL_LSB        6
`define PFSM_PULL_W          3
`define PFSM_FORCE_INPUT_ENABLE_BIT        9
`define PFSM_FORCE_OUTPUT_ENABLE_BIT        10
`define PFSM_CFG_RESET       16'h0003
`define PFSM_SEL_ALT0        4'h0
`define PFSM_SEL_GPIO        4'h3
`define PFSM_SEL_TIMER       4'h6
`define PFSM_SEL_CS          4'h7
`define PFSM_SEL_FAST        4'hb
`define PFSM_SEL_MAX         4'hb
`define PFSM_SEL_HOLE        4'h8
`define PFSM_DS_TENTH        2'h0
`define PFSM_DS_HALF         2'h1
`define PFSM_DS_3Q           2'h2
`define PFSM_DS_FULL         2'h3
`define PFSM_PULL_NONE       3'h0
`define PFSM_PULL_DOWN       3'h1
`define PFSM_PULL_UP_WEAKEST 3'h7
`define PFSM_GRP_LO          37
`define PFSM_GRP_HI          45
`define PFSM_TRACE_PAD       28

`endif

/* File: pfsm_pkg.sv */
/*
 Types shared by the pad function select multiplexer files.
 Assumes pfsm_defines.svh is compiled in the same unit.
*/
`include "pfsm_defines.svh"

package pfsm_pkg;
    typedef logic [`PFSM_FSEL_W-1:0] pfsm_fsel_t;
    typedef logic [`PFSM_DS_W-1:0]   pfsm_drive_t;
    typedef logic [`PFSM_PULL_W-1:0] pfsm_pull_t;
    typedef enum logic [1:0] {
        PFSM_LOCKED   = 2'b01,
        PFSM_UNLOCKED = 2'b10
    } pfsm_key_state_t;
endpackage

/* File: pfsm_pad_slice.sv */
/*
 One pad: picks output and output enable from the twelve function
 lanes, input enable from a valid select, with force-enable overrides.
 Assumes configuration fields are registered in the parent.
*/
`timescale 1ns/1ps
`include "pfsm_defines.svh"

module pfsm_pad_slice
    import pfsm_pkg::*;
#(
    parameter bit FORCE_WORKS = 1'b1
) (
    input  wire logic [11:0] func_out_i,
    input  wire logic [11:0] func_oe_i,
    input  wire pfsm_fsel_t  function_select_i,
    input  wire logic        force_input_enable_i,
    input  wire logic        force_output_enable_i,
    output logic             pad_out_o,
    output logic             pad_oe_o,
    output logic             pad_ie_o
);
    logic sel_valid;
    logic sel_oe;

    always_comb begin
        // Unassigned codes leave the output disabled
        sel_valid = (function_select_i <= `PFSM_SEL_MAX) &&
                    (function_select_i != `PFSM_SEL_HOLE);
        sel_oe    = sel_valid ? func_oe_i[function_select_i] : 1'b0;
        pad_out_o = sel_valid ? func_out_i[function_select_i] : 1'b0;
        pad_oe_o  = sel_oe | (FORCE_WORKS & force_output_enable_i);
        pad_ie_o  = sel_valid | (FORCE_WORKS & force_input_enable_i);
    end
endmodule

/* File: pfsm_top.sv */
/*
 Pad function select multiplexer: key-gated per-pad configuration,
 function routing, drive and pull selection, force enables.
 Assumes a single system clock, synchronous reset and peripheral
 signals on the same clock; pad inputs arrive asynchronous.
*/
// Overview of operation
// - Config writes accepted only while key register holds the unlock value.
// - Every pad 0 to 104 has a function select choosing one of eleven signals.
// - Tenth and half drive everywhere; three-quarter and full on capable pads only.
// - Bonded pads pick pull-down or one of six pull-ups.
// - Force bits keep input or output enable active regardless of function.
// - Without force bits the selected function drives output enable.
// - Force bits have no effect on pad zero.
// - Pads 37 to 45 at select zero serve memory SPI chosen by pad group.
// - Boot loader drives pad 28 as serial trace output.
// - Select 3 general I/O, 6 timer, 7 chip select, 11 fast I/O.
`timescale 1ns/1ps
`include "pfsm_defines.svh"

module pfsm_top
    import pfsm_pkg::*;
#(
    parameter int                          NUM_PADS   = `PFSM_NUM_PADS,
    parameter logic [`PFSM_NUM_PADS-1:0]   FULL_DRIVE = '1,
    parameter logic [`PFSM_NUM_PADS-1:0]   BONDED     = '1
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         key_write_i,
    input  wire logic [7:0]                   key_data_i,
    input  wire logic                         cfg_write_i,
    input  wire logic [6:0]                   cfg_index_i,
    input  wire logic [`PFSM_CFG_W-1:0]       cfg_data_i,
    input  wire logic [6:0]                   rd_index_i,
    input  wire logic                         boot_trace_en_i,
    input  wire logic                         boot_trace_val_i,
    input  wire logic                         device_pad_group_sel_i,
    input  wire logic [NUM_PADS-1:0]          msf_out_i,
    input  wire logic [NUM_PADS-1:0]          msf_oe_i,
    input  wire logic [NUM_PADS-1:0]          mss_out_i,
    input  wire logic [NUM_PADS-1:0]          mss_oe_i,
    input  wire logic [NUM_PADS*11-1:0]       func_out_i,
    input  wire logic [NUM_PADS*11-1:0]       func_oe_i,
    input  wire logic [NUM_PADS-1:0]          pad_in_i,
    output logic                              unlocked_o,
    output logic [`PFSM_CFG_W-1:0]            rd_data_o,
    output logic [NUM_PADS-1:0]               pad_out_o,
    output logic [NUM_PADS-1:0]               pad_oe_o,
    output logic [NUM_PADS-1:0]               pad_ie_o,
    output logic [NUM_PADS*`PFSM_DS_W-1:0]    drive_strength_sel_o,
    output logic [NUM_PADS*`PFSM_PULL_W-1:0]  pull_resistor_sel_o,
    output logic [NUM_PADS-1:0]               pad_in_sync_o
);
    pfsm_key_state_t             key_state_reg;
    logic [`PFSM_CFG_W-1:0]      pad_config_reg [`PFSM_NUM_REGS];
    logic [NUM_PADS-1:0]         in_s1_reg;
    logic [NUM_PADS-1:0]         in_s2_reg;
    logic [NUM_PADS-1:0]         in_s3_reg;
    logic [NUM_PADS-1:0]         in_stable_reg;
    logic [NUM_PADS-1:0]         mux_out;
    logic [NUM_PADS-1:0]         mux_oe;
    logic [NUM_PADS-1:0]         mux_ie;
    logic [`PFSM_CFG_W-1:0]      cfg_next;

    // Clamp drive and pull codes to what the pad supports
    function automatic logic [`PFSM_CFG_W-1:0] legalize(
        input logic [`PFSM_CFG_W-1:0] d,
        input logic                   full_ok,
        input logic                   bonded
    );
        logic [`PFSM_CFG_W-1:0] r;
        r = d;
        if (!full_ok && d[`PFSM_DS_LSB+1]) begin
            r[`PFSM_DS_LSB +: `PFSM_DS_W] = `PFSM_DS_HALF;
        end
        if (!bonded) begin
            r[`PFSM_PULL_LSB +: `PFSM_PULL_W] = `PFSM_PULL_NONE;
        end
        return r;
    endfunction

    // Key register: unlocked only while the unlock value is held
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            key_state_reg <= PFSM_LOCKED;
        end else if (key_write_i) begin
            key_state_reg <= (key_data_i == `PFSM_KEY_UNLOCK) ? PFSM_UNLOCKED
                                                              : PFSM_LOCKED;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            unlocked_o <= 1'b0;
        end else begin
            unlocked_o <= (key_state_reg == PFSM_UNLOCKED);
        end
    end

    always_comb begin
        cfg_next = legalize(cfg_data_i,
                            (cfg_index_i < 7'(NUM_PADS)) ? FULL_DRIVE[cfg_index_i] : 1'b0,
                            (cfg_index_i < 7'(NUM_PADS)) ? BONDED[cfg_index_i] : 1'b0);
    end

    // Configuration store
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `PFSM_NUM_REGS; i++) begin
                pad_config_reg[i] <= `PFSM_CFG_RESET;
            end
        end else if (boot_trace_en_i) begin
            pad_config_reg[`PFSM_TRACE_PAD][`PFSM_FSEL_LSB +: `PFSM_FSEL_W]
                <= `PFSM_SEL_ALT0;
        end else if (cfg_write_i && key_state_reg == PFSM_UNLOCKED) begin
            pad_config_reg[cfg_index_i] <= cfg_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= pad_config_reg[rd_index_i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PADS; g++) begin : gen_pad
            logic [11:0]            lane_out;
            logic [11:0]            lane_oe;
            logic                   alt_out;
            logic                   alt_oe;
            logic [`PFSM_CFG_W-1:0] cfg;

            assign cfg = pad_config_reg[g];

            if (g >= `PFSM_GRP_LO && g <= `PFSM_GRP_HI) begin : gen_grp
                // Select zero shared by both memory SPI instances
                assign alt_out = device_pad_group_sel_i ? mss_out_i[g] : msf_out_i[g];
                assign alt_oe  = device_pad_group_sel_i ? mss_oe_i[g]  : msf_oe_i[g];
            end else begin : gen_plain
                assign alt_out = msf_out_i[g];
                assign alt_oe  = msf_oe_i[g];
            end

            // Lane 0 is select zero, lanes 1..11 follow in code order
            always_comb begin
                lane_out = {func_out_i[g*11 +: 11], alt_out};
                lane_oe  = {func_oe_i[g*11 +: 11], alt_oe};
                if (g == `PFSM_TRACE_PAD && boot_trace_en_i) begin
                    lane_out[`PFSM_SEL_ALT0] = boot_trace_val_i;
                    lane_oe[`PFSM_SEL_ALT0]  = 1'b1;
                end
            end

            pfsm_pad_slice #(
                .FORCE_WORKS (g != 0)
            ) u_slice (
                .func_out_i            (lane_out),
                .func_oe_i             (lane_oe),
                .function_select_i     (cfg[`PFSM_FSEL_LSB +: `PFSM_FSEL_W]),
                .force_input_enable_i  (cfg[`PFSM_FORCE_INPUT_ENABLE_BIT]),
                .force_output_enable_i (cfg[`PFSM_FORCE_OUTPUT_ENABLE_BIT]),
                .pad_out_o             (mux_out[g]),
                .pad_oe_o              (mux_oe[g]),
                .pad_ie_o              (mux_ie[g])
            );

            always_ff @(posedge clk_sys_i) begin
                if (!rst_n_i) begin
                    drive_strength_sel_o[g*`PFSM_DS_W +: `PFSM_DS_W]   <= `PFSM_DS_TENTH;
                    pull_resistor_sel_o[g*`PFSM_PULL_W +: `PFSM_PULL_W] <= `PFSM_PULL_NONE;
                end else begin
                    drive_strength_sel_o[g*`PFSM_DS_W +: `PFSM_DS_W]
                        <= cfg[`PFSM_DS_LSB +: `PFSM_DS_W];
                    pull_resistor_sel_o[g*`PFSM_PULL_W +: `PFSM_PULL_W]
                        <= cfg[`PFSM_PULL_LSB +: `PFSM_PULL_W];
                end
            end
        end
    endgenerate

    // Pad drive registered at the boundary
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pad_out_o <= '0;
            pad_oe_o  <= '0;
            pad_ie_o  <= '0;
        end else begin
            pad_out_o <= mux_out;
            pad_oe_o  <= mux_oe;
            pad_ie_o  <= mux_ie;
        end
    end

    // Pad input synchroniser, change taken once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            in_s1_reg     <= '0;
            in_s2_reg     <= '0;
            in_s3_reg     <= '0;
            in_stable_reg <= '0;
        end else begin
            in_s1_reg     <= pad_in_i;
            in_s2_reg     <= in_s1_reg;
            in_s3_reg     <= in_s2_reg;
            in_stable_reg <= (in_s2_reg & in_s3_reg) |
                             (in_stable_reg & (in_s2_reg | in_s3_reg));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pad_in_sync_o <= '0;
        end else begin
            pad_in_sync_o <= in_stable_reg & mux_ie;
        end
    end
endmodule

/* File: pfsm_chk.sv */
/* Assertions on the pfsm_top ports.
   Assumes one clock domain; bound to every pfsm_top below. */
`timescale 1ns/1ps
module pfsm_chk #(parameter int NUM_PADS = 105) (
    input wire logic                   clk_sys_i,
    input wire logic                   rst_n_i,
    input wire logic                   key_write_i,
    input wire logic [7:0]             key_data_i,
    input wire logic                   cfg_write_i,
    input wire logic [6:0]             cfg_index_i,
    input wire logic [6:0]             rd_index_i,
    input wire logic                   boot_trace_en_i,
    input wire logic                   boot_trace_val_i,
    input wire logic                   device_pad_group_sel_i,
    input wire logic [NUM_PADS-1:0]    msf_out_i,
    input wire logic [NUM_PADS-1:0]    mss_out_i,
    input wire logic [NUM_PADS*11-1:0] func_out_i,
    input wire logic [NUM_PADS*11-1:0] func_oe_i,
    input wire logic                   unlocked_o,
    input wire logic [15:0]            rd_data_o,
    input wire logic [NUM_PADS-1:0]    pad_out_o,
    input wire logic [NUM_PADS-1:0]    pad_oe_o,
    input wire logic [NUM_PADS-1:0]    pad_ie_o,
    input wire logic [NUM_PADS*2-1:0]  drive_strength_sel_o,
    input wire logic [NUM_PADS*3-1:0]  pull_resistor_sel_o,
    input wire logic [NUM_PADS-1:0]    pad_in_i,
    input wire logic [NUM_PADS-1:0]    pad_in_sync_o
);
    logic [1:0] warm_reg;
    logic [2:0] age_reg;
    logic [6:0] ri_reg;
    logic [7:0] rp;
    always_ff @(posedge clk_sys_i) begin
        warm_reg <= rst_n_i ? {warm_reg[0], 1'b1} : 2'b00;
        ri_reg <= rd_index_i;
        age_reg <= !rst_n_i ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
    end
    // Pad shown on rd_data_o, once past reset
    assign rp = warm_reg[1] ? {1'b0, ri_reg} : 8'hff;
    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_KEY_ON: assert property (key_write_i && key_data_i == 8'h73 ##1 !key_write_i
        |=> unlocked_o) else $error("unlock not seen");
    AST_LOCKED_KEEP: assert property (warm_reg[1] && !unlocked_o && !$past(key_write_i)
        && cfg_write_i && cfg_index_i == rd_index_i ##1 $stable(rd_index_i)
        |=> $stable(rd_data_o)) else $error("locked write landed");
    AST_FORCE: assert property (rp == 8'd1 && rd_data_o[10:9] != 2'b00
        |-> (pad_oe_o[1] || !rd_data_o[10]) && (pad_ie_o[1] || !rd_data_o[9]))
        else $error("force enable ignored");
    AST_PAD0: assert property (rp == 8'd0 && rd_data_o[3:0] == 4'h8 |-> !pad_oe_o[0])
        else $error("pad zero forced");
    AST_HOLE: assert property (rp == 8'd1 && rd_data_o[10:9] == 2'b00
        && rd_data_o[3:0] == 4'h8 |-> !pad_oe_o[1] && !pad_ie_o[1]) else $error("hole on");
    AST_GPIO: assert property (rp == 8'd2 && rd_data_o[10:0] == 11'h003 |->
        pad_out_o[2] == $past(func_out_i[24]) && pad_oe_o[2] == $past(func_oe_i[24]))
        else $error("gpio lane wrong");
    AST_DRIVE: assert property (rp == 8'd5 |->
        {pull_resistor_sel_o[17:15], drive_strength_sel_o[11:10]} == rd_data_o[8:4])
        else $error("drive or pull wrong");
    AST_GROUP: assert property (rp == 8'd40 && rd_data_o[10:0] == 11'h000 |->
        pad_out_o[40] == ($past(device_pad_group_sel_i) ? $past(mss_out_i[40])
        : $past(msf_out_i[40]))) else $error("memory lane wrong");
    AST_BOOT: assert property ((boot_trace_en_i && $stable(boot_trace_val_i))[*3] |=>
        pad_oe_o[28] && pad_out_o[28] == $past(boot_trace_val_i)) else $error("trace idle");
    AST_SYNC_IN: assert property (age_reg >= 3'h5
        && $past(pad_in_i[3], 4) == $past(pad_in_i[3], 5)
        |-> pad_in_sync_o[3] == ($past(pad_in_i[3], 4) && pad_ie_o[3]))
        else $error("pad input sync wrong");
    cover property (unlocked_o && cfg_write_i);
    cover property (boot_trace_en_i[*3]);
    cover property (rp == 8'd40 && device_pad_group_sel_i);
endmodule
bind pfsm_top pfsm_chk #(.NUM_PADS(NUM_PADS)) u_chk (.*);

/* File: pfsm_pin_model.sv */
/* Peripheral lanes and pad pins around pfsm_top.
   Assumes the same clock; every lane may change each cycle. */
`timescale 1ns/1ps
module pfsm_pin_model (
    input  wire logic    clk_sys_i,
    input  wire logic    rst_n_i,
    output logic [104:0] msf_out_o,
    output logic [104:0] msf_oe_o,
    output logic [104:0] mss_out_o,
    output logic [104:0] mss_oe_o,
    output logic [1154:0] func_out_o,
    output logic [1154:0] func_oe_o,
    output logic [104:0] pad_in_o
);
    logic [31:0]   mix_reg;
    logic [1183:0] rep;
    always_ff @(posedge clk_sys_i) begin
        mix_reg <= rst_n_i ? mix_reg * 32'h0019660d + 32'h3c6ef35f : 32'h00000001;
    end
    assign rep = {37{mix_reg}};
    assign func_out_o = rep[1154:0];
    assign func_oe_o = rep[1183:29];
    assign msf_out_o = rep[104:0];
    assign msf_oe_o = rep[109:5];
    // Second memory lanes always differ from the first
    assign mss_out_o = ~rep[104:0];
    assign mss_oe_o = ~rep[109:5];
    assign pad_in_o = rep[140:36];
endmodule

/* File: tb.sv */
/* Self-checking bench for pfsm_top.
   Assumes pfsm_pin_model drives lanes and pins. */
`timescale 1ns/1ps
module tb;
    logic          clk_sys_i, rst_n_i, key_write_i, cfg_write_i, unlocked_o;
    logic          boot_trace_en_i, boot_trace_val_i, device_pad_group_sel_i;
    logic [7:0]    key_data_i;
    logic [6:0]    cfg_index_i, rd_index_i;
    logic [15:0]   cfg_data_i, rd_data_o;
    logic [104:0]  msf_out_i, msf_oe_i, mss_out_i, mss_oe_i, pad_in_i;
    logic [104:0]  pad_out_o, pad_oe_o, pad_ie_o, pad_in_sync_o;
    logic [1154:0] func_out_i, func_oe_i;
    logic [209:0]  drive_strength_sel_o;
    logic [314:0]  pull_resistor_sel_o;
    int            n_fail = 0, samples_checked = 0, cyc = 0;
    int            codes[4] = '{3, 6, 7, 11};

    // Pad 8 lacks the two strongest drive settings
    pfsm_top #(.FULL_DRIVE(~(105'h1 << 8))) dut (.*);
    pfsm_pin_model pins (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .msf_out_o(msf_out_i),
        .msf_oe_o(msf_oe_i), .mss_out_o(mss_out_i), .mss_oe_o(mss_oe_i),
        .func_out_o(func_out_i), .func_oe_o(func_oe_i), .pad_in_o(pad_in_i));

    task automatic print_verdict();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic key(input logic [7:0] v);
        @(posedge clk_sys_i);
        key_write_i <= 1'b1;
        key_data_i <= v;
        @(posedge clk_sys_i);
        key_write_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk("unlocked", 16'(v == 8'h73), 16'(unlocked_o));
    endtask
    task automatic cfg(input logic [6:0] i, input logic [15:0] d);
        @(posedge clk_sys_i);
        cfg_write_i <= 1'b1;
        cfg_index_i <= i;
        cfg_data_i <= d;
        @(posedge clk_sys_i);
        cfg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] i, input logic [15:0] e);
        @(posedge clk_sys_i);
        rd_index_i <= i;
        @(posedge clk_sys_i);
        #1;
        chk("config", e, rd_data_o);
    endtask
    // Lane values are captured one cycle ahead of the registered pad
    task automatic route(input int p, input int c);
        logic ev, eo;
        @(posedge clk_sys_i);
        #1;
        ev = c > 0 ? func_out_i[p*11+c-1] : device_pad_group_sel_i ? mss_out_i[p] : msf_out_i[p];
        eo = c > 0 ? func_oe_i[p*11+c-1] : device_pad_group_sel_i ? mss_oe_i[p] : msf_oe_i[p];
        @(posedge clk_sys_i);
        #1;
        chk("pad_out", 16'(ev), 16'(pad_out_o[p]));
        chk("pad_oe", 16'(eo), 16'(pad_oe_o[p]));
    endtask
    task automatic padst(input int p, input logic [15:0] d, input logic [15:0] e);
        cfg(7'(p), d);
        rd(7'(p), d);
        chk("pad_state", e, 16'({pad_oe_o[p], pad_ie_o[p], pull_resistor_sel_o[p*3+:3],
            drive_strength_sel_o[p*2+:2]}));
    endtask
    task automatic boot(input logic v);
        @(posedge clk_sys_i);
        boot_trace_en_i <= 1'b1;
        boot_trace_val_i <= v;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk("trace_pad", {15'h0001, v}, 16'({pad_oe_o[28], pad_out_o[28]}));
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        {rst_n_i, key_write_i, cfg_write_i, boot_trace_en_i, boot_trace_val_i} = '0;
        {device_pad_group_sel_i, key_data_i, cfg_index_i, rd_index_i, cfg_data_i} = '0;
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(7'd0, 16'h0003);
        rd(7'd104, 16'h0003);
        rd(7'd127, 16'h0003);
        rd(7'd1, 16'h0003);
        cfg(7'd1, 16'h0008);
        rd(7'd1, 16'h0003);
        key(8'h73);
        foreach (codes[i]) begin
            cfg(7'd2, 16'(codes[i]));
            rd(7'd2, 16'(codes[i]));
            route(2, codes[i]);
        end
        padst(1, 16'h0408, 16'h0040);
        padst(1, 16'h0208, 16'h0020);
        padst(1, 16'h0008, 16'h0000);
        padst(0, 16'h0608, 16'h0000);
        padst(5, 16'h01f8, 16'h001f);
        padst(6, 16'h0058, 16'h0005);
        padst(7, 16'h0088, 16'h0008);
        cfg(7'd8, 16'h01f8);
        rd(7'd8, 16'h01d8);
        for (int i = 37; i <= 73; i++)
            if (i <= 45 || i >= 64) cfg(7'(i), 16'h0000);
        rd(7'd40, 16'h0000);
        route(40, 0);
        @(posedge clk_sys_i);
        device_pad_group_sel_i <= 1'b1;
        route(40, 0);
        rd(7'd7, 16'h0088);
        key(8'h00);
        cfg(7'd7, 16'h0003);
        rd(7'd7, 16'h0088);
        rd(7'd4, 16'h0003);
        boot(1'b1);
        boot(1'b0);
        print_verdict();
    end
endmodule
